/* File: rtl/osc_trim_settle_pkg.sv */
// constants, register layouts and types of the oscillator trim and settle control block
// Overview of operation
// R1 - settled flag rises only after the crystal has had its full settle time; here a settle delay of n ends after n-1 to n tick periods
// R2 - trim-ready flag is high while applied trim equals programmed trim; resets high
// R3 - status bit 5 shows debug domain up, bit 4 down; bit 4 resets high
// R4 - status bit 3 shows peripheral domain up, bit 2 down; bit 2 resets high
// R5 - status bit 1 shows radio domain up, bit 0 down; bit 0 resets high
// R6 - trim delay field 7:4 counts 250 us ticks before applying trim; reset 0xa
// R7 - settle delay field 3:0 counts ticks from trim apply to settled; reset 0x2
// R8 - the 250 us tick is the 16 MHz rc clock divided by 4000
// R9 - bit 12 of low-frequency control turns off crystal amplitude regulation
// R10 - bits 11:8 trim the 32 kHz rc frequency; reset 0x7
// R11 - bit 7 enables the 32 kHz rc oscillator; resets to one
// R12 - bits 6:3 set 32 kHz crystal bias current; reset 0x3
// R13 - bits 2:1 set 32 kHz crystal bias resistor; reset 0x2
// R14 - bit 0 enables the 32 kHz crystal; resets to zero
// R15 - software sets bias sample-hold bit 8 on wakeup, clears before deep sleep
// R16 - bits 7:5 set 16 MHz crystal bias current; reset 0x5
// R17 - bits 4:1 trim 16 MHz rc frequency, bit 0 enables it; both reset zero
// R18 - rcx control bit 12 selects rcx over the 32 kHz rc; resets zero
// R19 - rcx control holds enable, low-freq, bias, temperature and trim; trim resets 8
// R20 - software keeps the reference low-power test bit 14 at zero
// R21 - software keeps retention regulator trim at or above voltage of code 0xa
// R22 - bit 9 of high-frequency control enables crystal noise filter; resets zero
// R23 - software waits for settled or trim-ready before using the crystal clock
// R24 - reserved bits read zero and ignore writes
package osc_trim_settle_pkg;

    localparam int ADDR_W = 32;
    localparam int DATA_W = 16;

    // register addresses
    localparam logic [ADDR_W-1:0] SYSTEM_STATUS_ADDR = 32'h5000_0014;
    localparam logic [ADDR_W-1:0] CRYSTAL_TRIM_TIMING_ADDR = 32'h5000_0016;
    localparam logic [ADDR_W-1:0] LOW_FREQ_OSC_CONTROL_ADDR = 32'h5000_0020;
    localparam logic [ADDR_W-1:0] HIGH_FREQ_OSC_CONTROL_ADDR = 32'h5000_0022;
    localparam logic [ADDR_W-1:0] RCX_OSC_CONTROL_ADDR = 32'h5000_0024;
    localparam logic [ADDR_W-1:0] BANDGAP_TRIM_ADDR = 32'h5000_0028;

    // tick timing: the tick period in us and the rc oscillator rate in kHz
    localparam int TICK_PERIOD_US = 250;
    localparam int RC_CLOCK_KHZ = 16000;
    localparam int TICK_DIVIDE = TICK_PERIOD_US * RC_CLOCK_KHZ / 1000;
    localparam int DIV_W = 12;
    localparam int DELAY_W = 4;

    // status register layout
    typedef struct packed {
        logic [7:0] reserved;
        logic hf_crystal_settled;
        logic hf_trim_applied;
        logic debug_domain_up;
        logic debug_domain_down;
        logic periph_domain_up;
        logic periph_domain_down;
        logic radio_domain_up;
        logic radio_domain_down;
    } system_status_t;

    typedef struct packed {
        logic [7:0] reserved;
        logic [3:0] trim_delay;
        logic [3:0] settle_delay;
    } crystal_trim_timing_t;

    typedef struct packed {
        logic [2:0] reserved;
        logic lf_crystal_amp_reg_off;
        logic [3:0] lf_rc_freq_trim;
        logic lf_rc_on;
        logic [3:0] lf_crystal_bias_current;
        logic [1:0] lf_crystal_bias_resistor;
        logic lf_crystal_on;
    } low_freq_osc_control_t;

    typedef struct packed {
        logic [5:0] reserved;
        logic hf_crystal_noise_filter_on;
        logic hf_bias_sample_hold_on;
        logic [2:0] hf_crystal_bias_current;
        logic [3:0] hf_rc_freq_trim;
        logic hf_rc_on;
    } high_freq_osc_control_t;

    typedef struct packed {
        logic [2:0] reserved;
        logic alt_rc_select;
        logic alt_rc_on;
        logic alt_rc_extra_low_freq;
        logic [1:0] alt_rc_bias;
        logic [3:0] alt_rc_temp_control;
        logic [3:0] alt_rc_freq_trim;
    } rcx_osc_control_t;

    typedef struct packed {
        logic reserved;
        logic reference_low_power_test;
        logic [3:0] retention_regulator_trim;
        logic [4:0] reference_bias_trim;
        logic [4:0] reference_voltage_trim;
    } bandgap_trim_t;

    // reset values
    localparam crystal_trim_timing_t CRYSTAL_TRIM_TIMING_RST = '{8'h00, 4'ha, 4'h2};
    localparam low_freq_osc_control_t LOW_FREQ_OSC_CONTROL_RST =
        '{3'h0, 1'h0, 4'h7, 1'h1, 4'h3, 2'h2, 1'h0};
    localparam high_freq_osc_control_t HIGH_FREQ_OSC_CONTROL_RST =
        '{6'h00, 1'h0, 1'h0, 3'h5, 4'h0, 1'h0};
    localparam rcx_osc_control_t RCX_OSC_CONTROL_RST =
        '{3'h0, 1'h0, 1'h0, 1'h0, 2'h1, 4'h7, 4'h8};
    localparam bandgap_trim_t BANDGAP_TRIM_RST = '{1'h0, 1'h0, 4'h0, 5'h00, 5'h00};
    // power-domain flags reset to "down"
    localparam logic [5:0] DOMAIN_FLAGS_RST = 6'h15;
    localparam logic TRIM_READY_RST = 1'h1;

    // crystal trim and settle sequencer
    typedef enum logic [3:0] {
        SEQ_OFF = 4'h1,
        SEQ_TRIM_WAIT = 4'h2,
        SEQ_SETTLE_WAIT = 4'h4,
        SEQ_RUNNING = 4'h8
    } seq_state_t;

endpackage

/* File: rtl/osc_trim_settle_control.sv */
// oscillator trim-apply and settle sequencer with clock source control registers
`timescale 1ns/10ps
`default_nettype none
module osc_trim_settle_control
    import osc_trim_settle_pkg::*;
#(
    parameter int TRIM_W = 8,
    parameter int TICK_DIV = TICK_DIVIDE
) (
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [DATA_W-1:0] reg_rdata,
    // crystal and trim
    input wire logic hf_crystal_enable,
    input wire logic [TRIM_W-1:0] hf_frequency_trim_value,
    input wire logic hf_rc_clock,
    output logic [TRIM_W-1:0] hf_applied_trim,
    output logic hf_crystal_settled,
    output logic hf_trim_applied,
    // power domain state from the power controller
    input wire logic debug_power_domain,
    input wire logic periph_power_domain,
    input wire logic radio_power_domain,
    // oscillator and reference controls
    output low_freq_osc_control_t low_freq_osc_control,
    output high_freq_osc_control_t high_freq_osc_control,
    output rcx_osc_control_t rcx_osc_control,
    output bandgap_trim_t bandgap_trim
);

    // the divider counter must hold the divide value minus one and the divide must be at least two
    if (TICK_DIV < 2 || TICK_DIV > (1 << DIV_W)) begin : g_bad_div
        $error("TICK_DIV out of range");
    end
    if (TRIM_W < 1 || TRIM_W > DATA_W) begin : g_bad_trim
        $error("TRIM_W out of range");
    end

    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_DIV - 1);
    localparam logic [DIV_W-1:0] DIV_ZERO = '0;
    localparam logic [DELAY_W-1:0] DELAY_ZERO = '0;
    localparam logic [DELAY_W-1:0] DELAY_ONE = DELAY_W'(1);
    localparam logic [DIV_W-1:0] DIV_ONE = DIV_W'(1);

    typedef struct packed {
        logic [2:0] rc_sync;
        logic rc_level;
        logic [DIV_W-1:0] div_cnt;
        logic tick;
        seq_state_t seq;
        logic [DELAY_W-1:0] wait_cnt;
        logic settled;
        logic [TRIM_W-1:0] applied;
        logic trim_ready;
        logic [5:0] domain_flags;
        crystal_trim_timing_t timing;
        low_freq_osc_control_t lf;
        high_freq_osc_control_t hf;
        rcx_osc_control_t rcx;
        bandgap_trim_t bg;
        logic [DATA_W-1:0] rdata;
    } state_t;

    state_t s;
    state_t next_s;

    // read mux shared by the read path; unmapped addresses read zero
    function automatic logic [DATA_W-1:0] read_word(input state_t cur,
                                                     input logic [ADDR_W-1:0] addr);
        system_status_t st;
        logic [DATA_W-1:0] word;
        st = '0;
        st.hf_crystal_settled = cur.settled;
        st.hf_trim_applied = cur.trim_ready;
        {st.debug_domain_up, st.debug_domain_down, st.periph_domain_up,
         st.periph_domain_down, st.radio_domain_up, st.radio_domain_down} =
            cur.domain_flags;
        word = '0;
        unique case (addr)
            SYSTEM_STATUS_ADDR: word = st;
            CRYSTAL_TRIM_TIMING_ADDR: word = cur.timing;
            LOW_FREQ_OSC_CONTROL_ADDR: word = cur.lf;
            HIGH_FREQ_OSC_CONTROL_ADDR: word = cur.hf;
            RCX_OSC_CONTROL_ADDR: word = cur.rcx;
            BANDGAP_TRIM_ADDR: word = cur.bg;
            default: word = '0;
        endcase
        return word;
    endfunction

    // one step of a delay: true when the count has run out
    function automatic logic delay_done(input logic [DELAY_W-1:0] cnt);
        return cnt == DELAY_ZERO;
    endfunction

    always_comb begin
        next_s = s;

        // rc clock synchroniser; the level only moves when stages two and three agree
        next_s.rc_sync = {s.rc_sync[1:0], hf_rc_clock};
        if (s.rc_sync[1] == s.rc_sync[2]) begin
            next_s.rc_level = s.rc_sync[2];
        end

        // free-running divider: one tick per TICK_DIV rising rc edges [R8]
        next_s.tick = 1'b0;
        if (s.rc_sync[1] == s.rc_sync[2] && s.rc_sync[2] && !s.rc_level) begin
            if (s.div_cnt == DIV_LAST) begin
                next_s.div_cnt = DIV_ZERO; // [R8]
                next_s.tick = 1'b1;
            end else begin
                next_s.div_cnt = s.div_cnt + DIV_ONE;
            end
        end

        // trim-apply and settle sequence; a tick that is already running counts,
        // so a delay of n waits between n-1 and n whole tick periods
        unique case (s.seq)
            SEQ_OFF: begin
                next_s.settled = 1'b0;
                if (hf_crystal_enable) begin
                    next_s.wait_cnt = s.timing.trim_delay; // [R6]
                    next_s.seq = SEQ_TRIM_WAIT;
                end
            end
            SEQ_TRIM_WAIT: begin
                if (!hf_crystal_enable) begin
                    next_s.seq = SEQ_OFF;
                end else if (delay_done(s.wait_cnt)) begin
                    next_s.applied = hf_frequency_trim_value; // [R6]
                    next_s.wait_cnt = s.timing.settle_delay; // [R7]
                    next_s.seq = SEQ_SETTLE_WAIT;
                end else if (s.tick) begin
                    next_s.wait_cnt = s.wait_cnt - DELAY_ONE; // [R6]
                end
            end
            SEQ_SETTLE_WAIT: begin
                if (!hf_crystal_enable) begin
                    next_s.seq = SEQ_OFF;
                end else if (delay_done(s.wait_cnt)) begin
                    next_s.settled = 1'b1; // [R1] [R7]
                    next_s.seq = SEQ_RUNNING;
                end else if (s.tick) begin
                    next_s.wait_cnt = s.wait_cnt - DELAY_ONE; // [R7]
                end
            end
            SEQ_RUNNING: begin
                // a new programmed trim is taken over at once once the crystal has settled
                next_s.applied = hf_frequency_trim_value;
                if (!hf_crystal_enable) begin
                    next_s.settled = 1'b0;
                    next_s.seq = SEQ_OFF;
                end
            end
            default: begin
                next_s.settled = 1'b0;
                next_s.seq = SEQ_OFF;
            end
        endcase

        // trim-ready compares what the crystal sees with the programmed value
        next_s.trim_ready = (s.applied == hf_frequency_trim_value); // [R2]

        // power domain flags, up and down as complements [R3] [R4] [R5]
        next_s.domain_flags = {debug_power_domain, !debug_power_domain,
                               periph_power_domain, !periph_power_domain,
                               radio_power_domain, !radio_power_domain};

        // register writes; reserved fields are forced back to zero [R24]
        if (reg_write) begin
            unique case (reg_addr)
                CRYSTAL_TRIM_TIMING_ADDR: begin
                    next_s.timing = reg_wdata; // [R6] [R7]
                    next_s.timing.reserved = '0; // [R24]
                end
                LOW_FREQ_OSC_CONTROL_ADDR: begin
                    next_s.lf = reg_wdata; // [R9] [R10] [R11] [R12] [R13] [R14]
                    next_s.lf.reserved = '0; // [R24]
                end
                HIGH_FREQ_OSC_CONTROL_ADDR: begin
                    next_s.hf = reg_wdata; // [R16] [R17] [R22]
                    next_s.hf.reserved = '0; // [R24]
                end
                RCX_OSC_CONTROL_ADDR: begin
                    next_s.rcx = reg_wdata; // [R18] [R19]
                    next_s.rcx.reserved = '0; // [R24]
                end
                BANDGAP_TRIM_ADDR: begin
                    // test and retention trim codes are stored as written
                    next_s.bg = reg_wdata;
                    next_s.bg.reserved = '0; // [R24]
                end
                default: begin
                end
            endcase
        end

        // read data stand only in the cycle after the strobe
        next_s.rdata = reg_read ? read_word(s, reg_addr) : '0; // [R24]
    end

    // single state register with synchronous reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s <= '0;
            s.seq <= SEQ_OFF;
            s.trim_ready <= TRIM_READY_RST; // [R2]
            s.domain_flags <= DOMAIN_FLAGS_RST; // [R3] [R4] [R5]
            s.timing <= CRYSTAL_TRIM_TIMING_RST; // [R6] [R7]
            s.lf <= LOW_FREQ_OSC_CONTROL_RST; // [R10] [R11] [R12] [R13] [R14]
            s.hf <= HIGH_FREQ_OSC_CONTROL_RST; // [R16] [R17] [R22]
            s.rcx <= RCX_OSC_CONTROL_RST; // [R18] [R19]
            s.bg <= BANDGAP_TRIM_RST;
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from the state register
    assign reg_rdata = s.rdata;
    assign hf_applied_trim = s.applied;
    assign hf_crystal_settled = s.settled; // [R1]
    assign hf_trim_applied = s.trim_ready; // [R2]
    assign low_freq_osc_control = s.lf;
    assign high_freq_osc_control = s.hf;
    assign rcx_osc_control = s.rcx;
    assign bandgap_trim = s.bg;

endmodule
`default_nettype wire

/* File: verification/osc_trim_settle_control_monitor.sv */
// port assertions for the oscillator trim and settle control block
`timescale 1ns/10ps
`default_nettype none
module osc_trim_settle_control_monitor
    import osc_trim_settle_pkg::*;
#(
    parameter int TRIM_W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic hf_crystal_enable,
    input wire logic [TRIM_W-1:0] hf_frequency_trim_value,
    input wire logic [TRIM_W-1:0] hf_applied_trim,
    input wire logic hf_crystal_settled,
    input wire logic hf_trim_applied,
    input wire logic debug_power_domain,
    input wire logic periph_power_domain,
    input wire logic radio_power_domain,
    input wire low_freq_osc_control_t low_freq_osc_control,
    input wire high_freq_osc_control_t high_freq_osc_control,
    input wire rcx_osc_control_t rcx_osc_control,
    input wire bandgap_trim_t bandgap_trim
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // crystal enable seen after being off
    sequence s_enable_rise;
        !hf_crystal_enable ##1 hf_crystal_enable;
    endsequence
    property p_reset_values;
        $rose(rst_n) |-> low_freq_osc_control == 16'h079c && high_freq_osc_control == 16'h00a0
            && rcx_osc_control == 16'h0178 && bandgap_trim == 16'h0000
            && !hf_crystal_settled && hf_trim_applied;
    endproperty
    a_reset_values: assert property (p_reset_values)
        else $error("outputs not at reset values");
    property p_wr_lf;
        reg_write && reg_addr == LOW_FREQ_OSC_CONTROL_ADDR
            |=> low_freq_osc_control == {3'h0, $past(reg_wdata[12:0])};
    endproperty
    a_wr_lf: assert property (p_wr_lf)
        else $error("low frequency control not written");
    property p_wr_hf;
        reg_write && reg_addr == HIGH_FREQ_OSC_CONTROL_ADDR
            |=> high_freq_osc_control == {6'h00, $past(reg_wdata[9:0])};
    endproperty
    a_wr_hf: assert property (p_wr_hf)
        else $error("high frequency control not written");
    property p_wr_rcx;
        reg_write && reg_addr == RCX_OSC_CONTROL_ADDR
            |=> rcx_osc_control == {3'h0, $past(reg_wdata[12:0])};
    endproperty
    a_wr_rcx: assert property (p_wr_rcx)
        else $error("rcx control not written");
    // test bit and retention trim are kept exactly as software wrote them
    property p_wr_bg;
        reg_write && reg_addr == BANDGAP_TRIM_ADDR
            |=> bandgap_trim == {1'h0, $past(reg_wdata[14:0])};
    endproperty
    a_wr_bg: assert property (p_wr_bg)
        else $error("bandgap trim not written");
    // a control output may only move on a write
    property p_hold;
        !reg_write |=> $stable(low_freq_osc_control) && $stable(high_freq_osc_control)
            && $stable(rcx_osc_control) && $stable(bandgap_trim);
    endproperty
    a_hold: assert property (p_hold)
        else $error("control output moved without a write");
    property p_rdata_idle;
        !reg_read |=> reg_rdata == 16'h0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero outside a read");
    // status word is the flag registers, domain flags one cycle behind their inputs
    property p_status;
        reg_read && reg_addr == SYSTEM_STATUS_ADDR |=> reg_rdata == {8'h00,
            $past(hf_crystal_settled), $past(hf_trim_applied),
            $past(debug_power_domain, 2), !$past(debug_power_domain, 2),
            $past(periph_power_domain, 2), !$past(periph_power_domain, 2),
            $past(radio_power_domain, 2), !$past(radio_power_domain, 2)};
    endproperty
    a_status: assert property (p_status)
        else $error("status word wrong");
    property p_ready;
        $past(rst_n) |-> hf_trim_applied == $past(hf_applied_trim == hf_frequency_trim_value);
    endproperty
    a_ready: assert property (p_ready)
        else $error("trim ready flag wrong");
    property p_settle_drop;
        !hf_crystal_enable |=> !hf_crystal_settled;
    endproperty
    a_settle_drop: assert property (p_settle_drop)
        else $error("settled flag kept without crystal enable");
    // even with zero delays apply and settle take their two steps
    property p_no_early_settle;
        s_enable_rise |-> (!hf_crystal_settled)[*3];
    endproperty
    a_no_early_settle: assert property (p_no_early_settle)
        else $error("settled flag rose too early");
endmodule
bind osc_trim_settle_control osc_trim_settle_control_monitor #(.TRIM_W(TRIM_W)) mon (
    .clk(clk),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_rdata(reg_rdata),
    .hf_crystal_enable(hf_crystal_enable),
    .hf_frequency_trim_value(hf_frequency_trim_value),
    .hf_applied_trim(hf_applied_trim),
    .hf_crystal_settled(hf_crystal_settled),
    .hf_trim_applied(hf_trim_applied),
    .debug_power_domain(debug_power_domain),
    .periph_power_domain(periph_power_domain),
    .radio_power_domain(radio_power_domain),
    .low_freq_osc_control(low_freq_osc_control),
    .high_freq_osc_control(high_freq_osc_control),
    .rcx_osc_control(rcx_osc_control),
    .bandgap_trim(bandgap_trim)
);
`default_nettype wire

/* File: verification/osc_trim_settle_control_tb.sv */
// self-checking bench for the oscillator trim and settle control block
`timescale 1ns/10ps
`default_nettype none
module osc_trim_settle_control_tb
    import osc_trim_settle_pkg::*;
;
    localparam int TD = 4;
    localparam int P = TD * 25 / 2; // clk cycles per tick: rc period 62.5 ns over 5 ns
    logic clk = 0, rst_n = 0, reg_write = 0, reg_read = 0, en = 0, rc = 0;
    logic [2:0] dom = 3'h0;
    logic [31:0] addr = 32'h0;
    logic [15:0] wdata = 16'h0, rdata;
    logic [7:0] trim = 8'h00, applied;
    logic settled, ready;
    int error_cnt = 0, n_compared = 0;
    logic [31:0] adr [6] = '{SYSTEM_STATUS_ADDR, CRYSTAL_TRIM_TIMING_ADDR,
        LOW_FREQ_OSC_CONTROL_ADDR, HIGH_FREQ_OSC_CONTROL_ADDR, RCX_OSC_CONTROL_ADDR,
        BANDGAP_TRIM_ADDR};
    logic [15:0] rstv [6] = '{16'h0055, 16'h00a2, 16'h079c, 16'h00a0, 16'h0178, 16'h0000};
    logic [15:0] ones [6] = '{16'h0055, 16'h00ff, 16'h1fff, 16'h03ff, 16'h1fff, 16'h2bff};
    initial forever #2.5 clk = ~clk;
    // rc clock free of the system clock phase; the offset keeps its edges off clk edges
    initial #1 forever #31.25 rc = ~rc;
    osc_trim_settle_control #(.TRIM_W(8), .TICK_DIV(TD)) dut (.clk(clk), .rst_n(rst_n),
        .reg_addr(addr), .reg_wdata(wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(rdata), .hf_crystal_enable(en), .hf_frequency_trim_value(trim),
        .hf_rc_clock(rc), .hf_applied_trim(applied), .hf_crystal_settled(settled),
        .hf_trim_applied(ready), .debug_power_domain(dom[2]), .periph_power_domain(dom[1]),
        .radio_power_domain(dom[0]), .low_freq_osc_control(), .high_freq_osc_control(),
        .rcx_osc_control(), .bandgap_trim());
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_write <= 1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        reg_write <= 0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [31:0] a, input logic [15:0] exp);
        @(posedge clk);
        reg_read <= 1;
        addr <= a;
        @(posedge clk);
        reg_read <= 0;
        #1 chk(rdata, exp);
    endtask
    // one crystal start: tick counts are free running, so n ticks last n-1 to n periods
    task automatic seq(input int n, input int m, input logic [7:0] t);
        int c;
        wr(CRYSTAL_TRIM_TIMING_ADDR, 16'(n * 16 + m));
        @(posedge clk);
        trim <= t;
        repeat (3) @(posedge clk);
        #1 chk(ready, 0);
        @(posedge clk);
        en <= 1;
        c = 0;
        while (applied !== t && c < 1000) begin
            @(posedge clk);
            #1 c++;
        end
        chk(c >= (n - 1) * P - 2 && c <= n * P + 8, 1);
        c = 0;
        while (settled !== 1'b1 && c < 1000) begin
            @(posedge clk);
            #1 c++;
        end
        chk(c >= (m - 1) * P - 2 && c <= m * P + 8, 1);
        rd(SYSTEM_STATUS_ADDR, {8'h00, 2'b11, dom[2], !dom[2], dom[1], !dom[1], dom[0],
            !dom[0]});
        @(posedge clk);
        trim <= ~t;
        repeat (3) @(posedge clk);
        #1 chk(applied, {8'h00, ~t});
        chk(ready, 1);
        @(posedge clk);
        en <= 0;
        repeat (2) @(posedge clk);
        #1 chk(settled, 0);
    endtask
    task automatic results;
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // watchdog: the tests need under two thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        results();
    end
    initial begin
        int c;
        repeat (12) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        foreach (adr[i]) rd(adr[i], rstv[i]);
        $display("test reset values done");
        // reserved bits and the status word refuse writes
        foreach (adr[i]) begin
            wr(adr[i], i == 5 ? 16'habff : 16'hffff);
            rd(adr[i], ones[i]);
            wr(adr[i], 16'h0000);
            rd(adr[i], i == 0 ? 16'h0055 : 16'h0000);
        end
        wr(32'h5000_0018, 16'hffff);
        rd(32'h5000_0018, 16'h0000);
        $display("test register access done");
        for (int k = 0; k < 8; k++) begin
            @(posedge clk);
            dom <= 3'(k);
            repeat (2) @(posedge clk);
            rd(SYSTEM_STATUS_ADDR, {8'h00, 2'b01, dom[2], !dom[2], dom[1], !dom[1], dom[0],
                !dom[0]});
        end
        $display("test power domains done");
        seq(0, 0, 8'h5a);
        seq(2, 3, 8'h21);
        // an enable dropped during the trim wait never settles
        wr(CRYSTAL_TRIM_TIMING_ADDR, 16'h0020);
        @(posedge clk);
        trim <= 8'h44;
        en <= 1;
        repeat (30) @(posedge clk);
        en <= 0;
        c = 0;
        repeat (200) begin
            @(posedge clk);
            #1 c += settled;
        end
        chk(c, 0);
        chk(applied, 16'h00de);
        chk(ready, 0);
        seq(1, 1, 8'h66);
        seq(10, 2, 8'h77);
        $display("test crystal sequencer done");
        results();
    end
endmodule
`default_nettype wire
